// ---- logic/cisub_core.sv ----
`timescale 1ns/1ps
module cisub_core (
	input  wire logic                      ref_clk_i,         // Core clock.
	input  wire logic                      rstn_i,            // Synchronous reset, low.
	input  wire logic                      hsel_i,            // AHB select.
	input  wire logic [31:0]               haddr_i,           // AHB address.
	input  wire logic [1:0]                htrans_i,          // AHB transfer type.
	input  wire logic                      hwrite_i,          // AHB write.
	input  wire logic [2:0]                hsize_i,           // AHB size, word only.
	input  wire logic [31:0]               hwdata_i,          // AHB write data.
	input  wire logic                      hready_i,          // AHB bus ready.
	output logic      [31:0]               hrdata_o,          // AHB read data.
	output logic                           hreadyout_o,       // AHB slave ready.
	output logic                           hresp_o,           // AHB response, OKAY.
	input  wire logic                      instr_valid_i,     // Fetched word valid.
	input  wire logic [15:0]               instr_i,           // Fetched word.
	input  wire logic                      instr_two_word_i,  // Word starts a two-word op.
	output logic                           instr_ready_o,     // Core takes a word.
	input  wire logic [7:0]                file_rdata_i,      // File data for last address.
	output cisub_pkg::cisub_file_req_t     file_req_o,        // File address and write.
	output logic                           skip_o             // Pulse: compare matched.
);
	cisub_pkg::cisub_state_t state;
	logic [7:0]  w;
	logic [4:0]  status;
	logic [3:0]  bank;
	logic [7:0]  latch;
	logic [21:0] tptr;
	logic [11:0] idxb;
	logic        ext_en;
	logic [7:0]  hold [8];
	logic [15:0] op_q;
	logic [1:0]  skip_cnt;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        ahb_take;
	logic        accept;
	logic        dropping;
	logic [8:0]  sum;
	logic [4:0]  nib;
	logic [7:0]  res;
	logic [4:0]  next_status;
	logic [21:0] next_tptr;
	logic [2:0]  hold_idx;
	function automatic logic [11:0] file_address(input logic [7:0] f, input logic a,
		input logic [3:0] b, input logic ext, input logic [11:0] base);
		if (!a && ext && f <= cisub_pkg::IDX_LIMIT)
			file_address = base + {4'h0, f};
		else if (!a)
			file_address = {(f < cisub_pkg::ACC_SPLIT) ? cisub_pkg::BANK_LOW :
				cisub_pkg::BANK_HIGH, f};
		else
			file_address = {b, f};
	endfunction : file_address
	function automatic logic is_file_op(input logic [15:0] ins);
		is_file_op = ins[15:10] == cisub_pkg::OPC_ADDC || ins[15:10] == cisub_pkg::OPC_COMP ||
			ins[15:9] == cisub_pkg::OPC_CMPEQ;
	endfunction : is_file_op
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		case (a)
			cisub_pkg::OFF_CTRL:   reg_read = {31'h0, ext_en};
			cisub_pkg::OFF_WREG:   reg_read = {24'h0, w};
			cisub_pkg::OFF_STATUS: reg_read = {27'h0, status};
			cisub_pkg::OFF_BANK:   reg_read = {28'h0, bank};
			cisub_pkg::OFF_LATCH:  reg_read = {24'h0, latch};
			cisub_pkg::OFF_TPTR:   reg_read = {10'h0, tptr};
			cisub_pkg::OFF_IDXB:   reg_read = {20'h0, idxb};
			cisub_pkg::OFF_HOLDLO: reg_read = {hold[3], hold[2], hold[1], hold[0]};
			cisub_pkg::OFF_HOLDHI: reg_read = {hold[7], hold[6], hold[5], hold[4]};
			default:               reg_read = 32'h0;
		endcase
	endfunction : reg_read
	assign ahb_take = hsel_i && htrans_i[1] && hready_i;
	assign accept = instr_valid_i && instr_ready_o;
	assign dropping = skip_cnt != cisub_pkg::SK_NONE;
	// Bus slave: zero wait states, read data loaded at the address-phase edge.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata_o <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			wr_pend <= ahb_take && hwrite_i;
			wr_addr <= haddr_i[7:0];
			hrdata_o <= (ahb_take && !hwrite_i) ? reg_read(haddr_i[7:0]) : 32'h0;
		end
	end
	// Registers that only software writes.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			ext_en <= 1'b0;
			bank <= 4'h0;
			latch <= 8'h00;
			idxb <= cisub_pkg::IDXB_RST;
		end
		else if (wr_pend)
		begin
			if (wr_addr == cisub_pkg::OFF_CTRL)
				ext_en <= hwdata_i[cisub_pkg::CTRL_EXT];
			if (wr_addr == cisub_pkg::OFF_BANK)
				bank <= hwdata_i[3:0];
			if (wr_addr == cisub_pkg::OFF_LATCH)
				latch <= hwdata_i[7:0];
			if (wr_addr == cisub_pkg::OFF_IDXB)
				idxb <= hwdata_i[11:0];
		end
	end
	// Datapath for the file-register operations, fed by the read data.
	always_comb
	begin
		sum = {1'b0, w} + {1'b0, file_rdata_i} + {8'h00, status[cisub_pkg::ST_C]};
		nib = {1'b0, w[3:0]} + {1'b0, file_rdata_i[3:0]} + {4'h0, status[cisub_pkg::ST_C]};
		next_status = status;
		res = file_rdata_i;
		if (op_q[15:10] == cisub_pkg::OPC_ADDC)
		begin
			res = sum[7:0];
			next_status[cisub_pkg::ST_C] = sum[8];
			next_status[cisub_pkg::ST_DC] = nib[4];
			next_status[cisub_pkg::ST_OV] = (w[7] == file_rdata_i[7]) && (sum[7] != w[7]);
			next_status[cisub_pkg::ST_N] = sum[7];
			next_status[cisub_pkg::ST_Z] = sum[7:0] == 8'h00;
		end
		else if (op_q[15:10] == cisub_pkg::OPC_COMP)
		begin
			res = ~file_rdata_i;
			next_status[cisub_pkg::ST_N] = ~file_rdata_i[7];
			next_status[cisub_pkg::ST_Z] = file_rdata_i == 8'hFF;
		end
	end
	// Pre-increment writes the byte after the pointer; the others write at the pointer.
	always_comb
	begin
		hold_idx = (instr_i[1:0] == cisub_pkg::TM_PRE_INC) ? tptr[2:0] + 3'h1 : tptr[2:0];
		case (instr_i[1:0])
			cisub_pkg::TM_NONE:     next_tptr = tptr;
			cisub_pkg::TM_POST_DEC: next_tptr = tptr - 22'h1;
			default:                next_tptr = tptr + 22'h1;
		endcase
	end
	// Sequencer. Software writes come first so that the core's own update wins.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			state <= cisub_pkg::CIS_IDLE;
			instr_ready_o <= 1'b1;
			w <= cisub_pkg::WREG_RST;
			status <= cisub_pkg::STATUS_RST;
			tptr <= cisub_pkg::TPTR_RST;
			op_q <= 16'h0000;
			skip_cnt <= cisub_pkg::SK_NONE;
			skip_o <= 1'b0;
			file_req_o <= '0;
			for (int i = 0; i < 8; i++)
				hold[i] <= 8'h00;
		end
		else
		begin
			skip_o <= 1'b0;
			file_req_o.we <= 1'b0;
			if (wr_pend && wr_addr == cisub_pkg::OFF_WREG)
				w <= hwdata_i[7:0];
			if (wr_pend && wr_addr == cisub_pkg::OFF_STATUS)
				status <= hwdata_i[4:0];
			if (wr_pend && wr_addr == cisub_pkg::OFF_TPTR)
				tptr <= hwdata_i[21:0];
			case (state)
				cisub_pkg::CIS_IDLE:
				begin
					if (accept && dropping)
					begin
						// The dropped word spends one cycle as a no-op.
						skip_cnt <= (skip_cnt == cisub_pkg::SK_FIRST && instr_two_word_i) ?
							cisub_pkg::SK_SECOND : cisub_pkg::SK_NONE;
					end
					else if (accept && instr_i[15:8] == cisub_pkg::OPC_ANDL)
					begin
						w <= w & instr_i[7:0];
						status[cisub_pkg::ST_N] <= w[7] & instr_i[7];
						status[cisub_pkg::ST_Z] <= (w & instr_i[7:0]) == 8'h00;
					end
					else if (accept && instr_i[15:2] == cisub_pkg::OPC_TBLW)
					begin
						hold[hold_idx] <= latch;
						tptr <= next_tptr;
						state <= cisub_pkg::CIS_TBLW;
						instr_ready_o <= 1'b0;
					end
					else if (accept && is_file_op(instr_i))
					begin
						op_q <= instr_i;
						file_req_o.addr <= file_address(instr_i[7:0], instr_i[8], bank,
							ext_en, idxb);
						state <= cisub_pkg::CIS_READ;
						instr_ready_o <= 1'b0;
					end
				end
				cisub_pkg::CIS_READ:
				begin
					state <= cisub_pkg::CIS_IDLE;
					instr_ready_o <= 1'b1;
					if (op_q[15:9] == cisub_pkg::OPC_CMPEQ)
					begin
						if (file_rdata_i == w)
						begin
							skip_cnt <= cisub_pkg::SK_FIRST;
							skip_o <= 1'b1;
						end
					end
					else
					begin
						status <= next_status;
						if (op_q[9])
						begin
							file_req_o.we <= 1'b1;
							file_req_o.wdata <= res;
						end
						else
							w <= res;
					end
				end
				// The second cycle of a table write ends here as well.
				default:
				begin
					state <= cisub_pkg::CIS_IDLE;
					instr_ready_o <= 1'b1;
				end
			endcase
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic take_word;
	assign take_word = accept && !dropping && !wr_pend;
	a_addc_carry: assert property (state == cisub_pkg::CIS_READ &&
		op_q[15:10] == cisub_pkg::OPC_ADDC && !wr_pend
		|=> status[cisub_pkg::ST_C] == $past(sum[8]) && status[cisub_pkg::ST_N] == $past(sum[7]))
		else $error("add with carry flags wrong");
	a_dest_file: assert property (state == cisub_pkg::CIS_READ && op_q[9] &&
		op_q[15:9] != cisub_pkg::OPC_CMPEQ |=> file_req_o.we && file_req_o.wdata == $past(res))
		else $error("file destination not written");
	a_dest_wreg: assert property (state == cisub_pkg::CIS_READ && !op_q[9] && !wr_pend &&
		op_q[15:9] != cisub_pkg::OPC_CMPEQ |=> !file_req_o.we && w == $past(res))
		else $error("working register destination wrong");
	a_bank_select: assert property (take_word && is_file_op(instr_i) && instr_i[8]
		|=> file_req_o.addr == {$past(bank), $past(instr_i[7:0])})
		else $error("banked address wrong");
	a_access_bank: assert property (take_word && is_file_op(instr_i) && !instr_i[8] &&
		!ext_en |=> file_req_o.addr[11:8] == (($past(instr_i[7:0]) < cisub_pkg::ACC_SPLIT) ?
		cisub_pkg::BANK_LOW : cisub_pkg::BANK_HIGH))
		else $error("access bank address wrong");
	a_indexed_addr: assert property (take_word && is_file_op(instr_i) && !instr_i[8] &&
		ext_en && instr_i[7:0] <= cisub_pkg::IDX_LIMIT
		|=> file_req_o.addr == $past(idxb) + {4'h0, $past(instr_i[7:0])})
		else $error("indexed address wrong");
	a_andl_flags: assert property (take_word && instr_i[15:8] == cisub_pkg::OPC_ANDL
		|=> w == ($past(w) & $past(instr_i[7:0])) && status[cisub_pkg::ST_C] ==
		$past(status[cisub_pkg::ST_C]) && status[cisub_pkg::ST_OV] == $past(status[cisub_pkg::ST_OV]))
		else $error("and literal result or flags wrong");
	a_comp_invert: assert property (state == cisub_pkg::CIS_READ && op_q[9] &&
		op_q[15:10] == cisub_pkg::OPC_COMP |=> file_req_o.wdata == ~$past(file_rdata_i))
		else $error("complement result wrong");
	a_cmp_flags: assert property (state == cisub_pkg::CIS_READ && !wr_pend &&
		op_q[15:9] == cisub_pkg::OPC_CMPEQ |=> $stable(status) && !file_req_o.we)
		else $error("compare changed flags");
	a_skip_drop: assert property (accept && skip_cnt == cisub_pkg::SK_FIRST &&
		!instr_two_word_i && !wr_pend |=> instr_ready_o && $stable(w) && skip_cnt == cisub_pkg::SK_NONE)
		else $error("skipped word not dropped");
	a_tblw_cycles: assert property (take_word && instr_i[15:2] == cisub_pkg::OPC_TBLW
		|=> !instr_ready_o ##1 instr_ready_o)
		else $error("table write not two cycles");
	a_tblw_ptr: assert property (take_word && instr_i[15:0] == {cisub_pkg::OPC_TBLW,
		cisub_pkg::TM_POST_DEC} |=> tptr == $past(tptr) - 22'h1)
		else $error("table pointer decrement wrong");
	c_skip_two: cover property (skip_o ##[1:20] (accept && instr_two_word_i && dropping));
	c_indexed: cover property (take_word && ext_en && !instr_i[8] && is_file_op(instr_i));
	c_preinc: cover property (take_word && instr_i[15:0] == {cisub_pkg::OPC_TBLW,
		cisub_pkg::TM_PRE_INC});
endmodule : cisub_core

// ---- logic/cisub_pkg.sv ----
package cisub_pkg;

	// Register byte offsets on the AHB-Lite port.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_WREG   = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_BANK   = 8'h0C;
	localparam logic [7:0] OFF_LATCH  = 8'h10;
	localparam logic [7:0] OFF_TPTR   = 8'h14;
	localparam logic [7:0] OFF_IDXB   = 8'h18;
	localparam logic [7:0] OFF_HOLDLO = 8'h1C;
	localparam logic [7:0] OFF_HOLDHI = 8'h20;

	// Status and control bit positions.
	localparam int ST_C  = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z  = 2;
	localparam int ST_OV = 3;
	localparam int ST_N  = 4;
	localparam int CTRL_EXT = 0;

	localparam logic [4:0]  STATUS_RST = 5'h00;
	localparam logic [7:0]  WREG_RST   = 8'h00;
	localparam logic [21:0] TPTR_RST   = 22'h000000;
	localparam logic [11:0] IDXB_RST   = 12'h000;

	// Opcode patterns on the upper instruction bits.
	localparam logic [5:0]  OPC_ADDC  = 6'h08;
	localparam logic [7:0]  OPC_ANDL  = 8'h0B;
	localparam logic [5:0]  OPC_COMP  = 6'h07;
	localparam logic [6:0]  OPC_CMPEQ = 7'h31;
	localparam logic [13:0] OPC_TBLW  = 14'h0003;

	// Access-bank split and literal-offset window limit.
	localparam logic [7:0] ACC_SPLIT  = 8'h60;
	localparam logic [7:0] IDX_LIMIT  = 8'h5F;
	localparam logic [3:0] BANK_LOW   = 4'h0;
	localparam logic [3:0] BANK_HIGH  = 4'hF;

	// Table pointer modes.
	localparam logic [1:0] TM_NONE = 2'h0;
	localparam logic [1:0] TM_POST_INC = 2'h1;
	localparam logic [1:0] TM_POST_DEC = 2'h2;
	localparam logic [1:0] TM_PRE_INC = 2'h3;

	// Skip tracker codes.
	localparam logic [1:0] SK_NONE = 2'h0;
	localparam logic [1:0] SK_FIRST = 2'h1;
	localparam logic [1:0] SK_SECOND = 2'h2;

	typedef enum logic [1:0] {
		CIS_IDLE = 2'b00,
		CIS_READ = 2'b01,
		CIS_TBLW = 2'b10
	} cisub_state_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        we;
	} cisub_file_req_t;

endpackage : cisub_pkg

// ---- verification/cisub_file_model.sv ----
`timescale 1ns/1ps
// Data register file seen by the core: a combinational read of the requested
// address and a write on the one-cycle strobe.
module cisub_file_model (
	input  wire logic                       ref_clk_i, // Core clock.
	input  wire cisub_pkg::cisub_file_req_t req_i,     // Address and write strobe.
	output logic      [7:0]                 rdata_o    // Content at the address.
);
	logic [7:0] mem [0:4095];

	assign rdata_o = mem[req_i.addr];

	// A plain process, since the bench also preloads the array directly.
	always @(posedge ref_clk_i)
	begin
		if (req_i.we)
		begin
			mem[req_i.addr] <= req_i.wdata;
		end
	end
endmodule : cisub_file_model

// ---- verification/cisub_core_tb.sv ----
`timescale 1ns/1ps
module cisub_core_tb;
	typedef struct packed {
		logic [15:0] ins;
		logic        ext;
		logic [7:0]  w;
		logic [4:0]  st;
		logic [11:0] fa;
		logic [7:0]  fv;
		logic [7:0]  ew;
		logic [4:0]  est;
		logic [7:0]  ef;
		logic        chase;
	} cisub_row_t;

	logic                       clk;
	logic                       rstn;
	logic                       hsel;
	logic [31:0]                haddr;
	logic [1:0]                 htrans;
	logic                       hwrite;
	logic [31:0]                hwdata;
	logic [31:0]                hrdata;
	logic                       hready;
	logic                       hresp;
	logic                       valid;
	logic [15:0]                instr;
	logic                       two;
	logic                       ready;
	logic [7:0]                 rdata;
	logic                       skip;
	cisub_pkg::cisub_file_req_t req;
	int                         failures;
	int                         checked;
	logic [31:0]                q;
	int                         n;
	logic                       sk;
	logic [21:0]                eptr [0:3] = '{22'h10, 22'h11, 22'h0F, 22'h11};
	// Compare rows end with a literal AND of zero, which shows whether it was dropped.
	cisub_row_t rows [0:9] = '{
		'{16'h2210, 0, 8'h4D, 5'h01, 12'h010, 8'h02, 8'h4D, 5'h02, 8'h50, 0},
		'{16'h2120, 0, 8'hFF, 5'h00, 12'h320, 8'h01, 8'h00, 5'h07, 8'h01, 0},
		'{16'h2005, 0, 8'h7F, 5'h01, 12'h005, 8'h00, 8'h80, 5'h1A, 8'h00, 0},
		'{16'h0B5F, 0, 8'hA3, 5'h1F, 12'h001, 8'h77, 8'h03, 5'h0B, 8'h77, 0},
		'{16'h1E80, 0, 8'h00, 5'h01, 12'hF80, 8'h13, 8'h00, 5'h11, 8'hEC, 0},
		'{16'h1C81, 0, 8'h11, 5'h00, 12'hF81, 8'hFF, 8'h00, 5'h04, 8'hFF, 0},
		'{16'h1E5F, 1, 8'h00, 5'h00, 12'h25F, 8'h0F, 8'h00, 5'h10, 8'hF0, 0},
		'{16'h1E60, 1, 8'h00, 5'h00, 12'hF60, 8'hAA, 8'h00, 5'h00, 8'h55, 0},
		'{16'h6230, 0, 8'h55, 5'h1F, 12'h030, 8'h55, 8'h55, 5'h1F, 8'h55, 1},
		'{16'h6230, 0, 8'h55, 5'h00, 12'h030, 8'h54, 8'h00, 5'h04, 8'h54, 1}
	};

	cisub_core i_dut (
		.ref_clk_i       (clk),
		.rstn_i          (rstn),
		.hsel_i          (hsel),
		.haddr_i         (haddr),
		.htrans_i        (htrans),
		.hwrite_i        (hwrite),
		.hsize_i         (3'h2),
		.hwdata_i        (hwdata),
		.hready_i        (hready),
		.hrdata_o        (hrdata),
		.hreadyout_o     (hready),
		.hresp_o         (hresp),
		.instr_valid_i   (valid),
		.instr_i         (instr),
		.instr_two_word_i(two),
		.instr_ready_o   (ready),
		.file_rdata_i    (rdata),
		.file_req_o      (req),
		.skip_o          (skip)
	);

	cisub_file_model i_mem (
		.ref_clk_i(clk),
		.req_i    (req),
		.rdata_o  (rdata)
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic results;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// The master waits on hready at each phase; only the watchdog ends a stuck wait.
	task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb

	// Returns in n the cycles the core held ready low after taking the word, and in sk
	// whether the skip pulse stood when ready came back.
	task automatic issue(input logic [15:0] w, input logic tw);
		@(posedge clk);
		valid <= 1'b1;
		instr <= w;
		two <= tw;
		do @(posedge clk); while (ready !== 1'b1);
		valid <= 1'b0;
		instr <= ~w;
		two <= 1'b0;
		n = 0;
		#1;
		while (ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		sk = skip;
	endtask : issue

	task automatic run(input cisub_row_t r);
		ahb(cisub_pkg::OFF_CTRL, 1'b1, {31'h0, r.ext});
		ahb(cisub_pkg::OFF_IDXB, 1'b1, 32'h200);
		ahb(cisub_pkg::OFF_BANK, 1'b1, 32'h3);
		ahb(cisub_pkg::OFF_WREG, 1'b1, {24'h0, r.w});
		ahb(cisub_pkg::OFF_STATUS, 1'b1, {27'h0, r.st});
		i_mem.mem[r.fa] = r.fv;
		issue(r.ins, 1'b0);
		chk({31'h0, sk}, {31'h0, r.chase && r.fv == r.w});
		if (r.chase)
			issue(16'h0B00, 1'b0);
		ahb(cisub_pkg::OFF_WREG, 1'b0, 32'h0);
		chk(q, {24'h0, r.ew});
		ahb(cisub_pkg::OFF_STATUS, 1'b0, 32'h0);
		chk(q, {27'h0, r.est});
		chk({24'h0, i_mem.mem[r.fa]}, {24'h0, r.ef});
	endtask : run

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#40000;
		failures++;
		results;
	end

	initial
	begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		valid = 1'b0;
		instr = 16'h0;
		two = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Every mapped register reads zero after reset, unmapped places too.
		for (int k = 0; k < 11; k++)
		begin
			ahb(8'(k * 4), 1'b0, 32'h0);
			chk(q, 32'h0);
		end
		chk({31'h0, hresp}, 32'h0);
		foreach (rows[i])
			run(rows[i]);
		// A skip over a two-word instruction drops both of its words.
		ahb(cisub_pkg::OFF_WREG, 1'b1, 32'h55);
		i_mem.mem[12'h030] = 8'h55;
		issue(16'h6230, 1'b0);
		chk(32'(n), 32'h1);
		chk({31'h0, sk}, 32'h1);
		issue(16'h0B00, 1'b1);
		issue(16'h0B00, 1'b0);
		issue(16'h0B0F, 1'b0);
		ahb(cisub_pkg::OFF_WREG, 1'b0, 32'h0);
		chk(q, 32'h05);
		for (int m = 0; m < 4; m++)
		begin
			ahb(cisub_pkg::OFF_TPTR, 1'b1, 32'h10);
			ahb(cisub_pkg::OFF_LATCH, 1'b1, 32'h50 + m);
			issue({cisub_pkg::OPC_TBLW, 2'(m)}, 1'b0);
			chk(32'(n), 32'h1);
			ahb(cisub_pkg::OFF_TPTR, 1'b0, 32'h0);
			chk(q, {10'h0, eptr[m]});
		end
		// The holding bytes are read-only from the bus.
		ahb(cisub_pkg::OFF_HOLDLO, 1'b1, 32'hFFFFFFFF);
		ahb(cisub_pkg::OFF_HOLDLO, 1'b0, 32'h0);
		chk(q, 32'h00005352);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		ahb(cisub_pkg::OFF_WREG, 1'b0, 32'h0);
		chk(q, 32'h0);
		results;
	end
endmodule : cisub_core_tb
